// >>> rtl/awmc_pkg.sv
package awmc_pkg;

	// ***********************************************************
	// Widths
	// ***********************************************************
	localparam int XLEN     = 64;
	localparam int HLEN     = 32;
	localparam int SEG_NUM  = 16;
	localparam int SEG_IDXW = 4;
	localparam int SEG_OFSW = 28;
	localparam int OP_W     = 3;

	// ***********************************************************
	// Segment table entry layout (64-bit)
	// ***********************************************************
	localparam int DESC_W       = 64;
	localparam int DESC_VSID_HI = 63;
	localparam int DESC_VSID_LO = 12;
	localparam int DESC_VALID   = 7;
	localparam int DESC_NOEXEC  = 6;
	localparam int VSID_W      = DESC_VSID_HI - DESC_VSID_LO + 1;
	localparam int VA_W        = VSID_W + SEG_OFSW;

	// ***********************************************************
	// Reset values
	// ***********************************************************
	localparam logic [XLEN-1:0]  RST_WORD = 64'h0000_0000_0000_0000;
	localparam logic [DESC_W-1:0] RST_DESC = 64'h0000_0000_0000_0000;
	localparam logic [HLEN-1:0]  ZERO_HI  = 32'h0000_0000;

	typedef enum logic [OP_W-1:0] {
		AWMC_OP_ADD,
		AWMC_OP_SUB,
		AWMC_OP_AND,
		AWMC_OP_OR,
		AWMC_OP_XOR,
		AWMC_OP_CMP
	} awmc_op_t;

endpackage

// >>> rtl/awmc_slb.sv
`timescale 1ns/100ps

module awmc_lookaside
	import awmc_pkg::*;
#(
	parameter int ENTRIES = SEG_NUM,
	parameter int IDX_W   = SEG_IDXW
)
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               ce,
	// Maintenance
	input  wire logic               wr_en,
	input  wire logic [IDX_W-1:0]   wr_idx,
	input  wire logic [DESC_W-1:0]  wr_data,
	input  wire logic               inval_all,
	// Lookup
	input  wire logic [IDX_W-1:0]   rd_idx,
	output logic      [DESC_W-1:0]  rd_data
);

	logic [DESC_W-1:0] entry_ff     [ENTRIES];
	logic [DESC_W-1:0] nxt_entry    [ENTRIES];

	// ***********************************************************
	// One lookaside entry per segment descriptor
	// ***********************************************************
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++)
		begin : g_ent
			always_comb
			begin
				nxt_entry[g] = entry_ff[g];
				// Write wins over a global invalidate in the same cycle
				if (inval_all)
					nxt_entry[g] = RST_DESC;
				if (wr_en && (wr_idx == IDX_W'(g)))
					nxt_entry[g] = wr_data;
			end

			always_ff @(posedge clock)
			begin
				if (rst)
					entry_ff[g] <= RST_DESC;
				else if (ce)
					entry_ff[g] <= nxt_entry[g];
			end
		end
	endgenerate

	assign rd_data = entry_ff[rd_idx];

endmodule

// >>> rtl/awmc_top.sv
`timescale 1ns/100ps

module awmc_top
	import awmc_pkg::*;
#(
	parameter bit SUBSET_32 = 1'b0,
	parameter bit BRIDGE_EN = 1'b1
)
(
	// Clock, reset, enable
	input  wire logic                 CLOCK,
	input  wire logic                 RST,
	input  wire logic                 CE,
	// Machine state
	input  wire logic                 ADDR_WIDTH_SELECT,
	output logic                      MODE_64,
	// Arithmetic request
	input  wire logic                 REQ_VALID,
	input  wire logic [OP_W-1:0]      OP_SEL,
	input  wire logic                 OP_DOUBLE,
	input  wire logic [XLEN-1:0]      OP_A,
	input  wire logic [XLEN-1:0]      OP_B,
	input  wire logic                 CARRY_IN,
	// Arithmetic answer
	output logic                      RSP_VALID,
	output logic      [XLEN-1:0]      RESULT,
	output logic                      CARRY_OUT,
	output logic                      OVERFLOW,
	output logic                      CMP_LT,
	output logic                      CMP_GT,
	output logic                      CMP_EQ,
	output logic                      EMUL_TRAP,
	// Effective address
	input  wire logic                 EA_VALID,
	input  wire logic [XLEN-1:0]      EA_BASE,
	input  wire logic [XLEN-1:0]      EA_DISP,
	output logic                      EA_RSP_VALID,
	output logic      [XLEN-1:0]      EA_OUT,
	output logic      [VA_W-1:0]      VA_OUT,
	output logic                      VA_VALID,
	output logic                      SEG_FAULT,
	output logic                      SEG_NOEXEC,
	// Loop count register
	input  wire logic                 LOOP_LOAD,
	input  wire logic [XLEN-1:0]      LOOP_LOAD_VAL,
	input  wire logic                 LOOP_DECR,
	output logic      [XLEN-1:0]      LOOP_VALUE,
	output logic                      LOOP_ZERO,
	// Segment lookaside maintenance
	input  wire logic                 LKA_WR,
	input  wire logic [SEG_IDXW-1:0]  LKA_WR_IDX,
	input  wire logic [DESC_W-1:0]    LKA_WR_DATA,
	input  wire logic                 LKA_INVAL_ALL
);

	// ***********************************************************
	// Mode
	// ***********************************************************
	logic narrow;

	// A 32-bit-only build ignores the select bit entirely
	assign narrow  = SUBSET_32 | ~ADDR_WIDTH_SELECT;
	assign MODE_64 = ~narrow;

	// ***********************************************************
	// Arithmetic datapath
	// ***********************************************************
	logic [XLEN-1:0] b_eff;
	logic            cin_eff;
	logic            use_sub;
	logic [XLEN:0]   sum_w;
	logic [HLEN:0]   sum_lo;
	logic            c64;
	logic            c32;
	logic            v64;
	logic            v32;
	logic [XLEN-1:0] alu_val;
	logic            trap_req;

	always_comb
	begin
		use_sub = (OP_SEL == AWMC_OP_SUB) || (OP_SEL == AWMC_OP_CMP);
		b_eff   = use_sub ? ~OP_B : OP_B;
		cin_eff = use_sub ? 1'b1 : CARRY_IN;
		sum_w   = {1'b0, OP_A} + {1'b0, b_eff} + {{XLEN{1'b0}}, cin_eff};
		sum_lo  = {1'b0, OP_A[HLEN-1:0]} + {1'b0, b_eff[HLEN-1:0]}
			+ {{HLEN{1'b0}}, cin_eff};
		c64     = sum_w[XLEN];
		c32     = sum_lo[HLEN];
		v64     = (OP_A[XLEN-1] == b_eff[XLEN-1])
			&& (sum_w[XLEN-1] != OP_A[XLEN-1]);
		v32     = (OP_A[HLEN-1] == b_eff[HLEN-1])
			&& (sum_lo[HLEN-1] != OP_A[HLEN-1]);
		case (OP_SEL)
			AWMC_OP_ADD: alu_val = sum_w[XLEN-1:0];
			AWMC_OP_SUB: alu_val = sum_w[XLEN-1:0];
			AWMC_OP_CMP: alu_val = sum_w[XLEN-1:0];
			AWMC_OP_AND: alu_val = OP_A & OP_B;
			AWMC_OP_OR:  alu_val = OP_A | OP_B;
			AWMC_OP_XOR: alu_val = OP_A ^ OP_B;
			default:     alu_val = RST_WORD;
		endcase
		// Doubleword work has no hardware on a 32-bit-only build
		trap_req = SUBSET_32 & OP_DOUBLE;
	end

	// ***********************************************************
	// Arithmetic answer registers
	// ***********************************************************
	logic            rsp_valid_ff;
	logic [XLEN-1:0] result_ff;
	logic            carry_ff;
	logic            ovf_ff;
	logic            lt_ff;
	logic            gt_ff;
	logic            eq_ff;
	logic            trap_ff;
	logic            nxt_rsp_valid;
	logic [XLEN-1:0] nxt_result;
	logic            nxt_carry;
	logic            nxt_ovf;
	logic            nxt_lt;
	logic            nxt_gt;
	logic            nxt_eq;
	logic            nxt_trap;
	logic            sign_w;
	logic            zero_w;

	always_comb
	begin
		nxt_rsp_valid = REQ_VALID;
		nxt_result    = result_ff;
		nxt_carry     = carry_ff;
		nxt_ovf       = ovf_ff;
		nxt_lt        = lt_ff;
		nxt_gt        = gt_ff;
		nxt_eq        = eq_ff;
		nxt_trap      = REQ_VALID & trap_req;
		sign_w        = narrow ? alu_val[HLEN-1] : alu_val[XLEN-1];
		zero_w        = narrow ? (alu_val[HLEN-1:0] == ZERO_HI)
			: (alu_val == RST_WORD);
		if (REQ_VALID)
		begin
			if (trap_req)
			begin
				// Software completes the operation; flags stay untouched
				nxt_result = RST_WORD;
			end
			else
			begin
				nxt_result = alu_val;
				if (SUBSET_32)
					nxt_result = {ZERO_HI, alu_val[HLEN-1:0]};
				nxt_carry = narrow ? c32 : c64;
				nxt_ovf   = narrow ? v32 : v64;
				if (OP_SEL == AWMC_OP_CMP)
				begin
					// Signed order: sign of the difference corrected by overflow
					nxt_lt = sign_w ^ nxt_ovf;
					nxt_eq = zero_w;
					nxt_gt = ~nxt_lt & ~zero_w;
				end
				else
				begin
					// Non-compare ops report sign and zero of the result
					nxt_lt = sign_w;
					nxt_eq = zero_w;
					nxt_gt = ~sign_w & ~zero_w;
				end
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			rsp_valid_ff <= 1'b0;
			result_ff    <= RST_WORD;
			carry_ff     <= 1'b0;
			ovf_ff       <= 1'b0;
			lt_ff        <= 1'b0;
			gt_ff        <= 1'b0;
			eq_ff        <= 1'b0;
			trap_ff      <= 1'b0;
		end
		else if (CE)
		begin
			rsp_valid_ff <= nxt_rsp_valid;
			result_ff    <= nxt_result;
			carry_ff     <= nxt_carry;
			ovf_ff       <= nxt_ovf;
			lt_ff        <= nxt_lt;
			gt_ff        <= nxt_gt;
			eq_ff        <= nxt_eq;
			trap_ff      <= nxt_trap;
		end
	end

	assign RSP_VALID = rsp_valid_ff;
	assign RESULT    = result_ff;
	assign CARRY_OUT = carry_ff;
	assign OVERFLOW  = ovf_ff;
	assign CMP_LT    = lt_ff;
	assign CMP_GT    = gt_ff;
	assign CMP_EQ    = eq_ff;
	assign EMUL_TRAP = trap_ff;

	// ***********************************************************
	// Effective address and bridge lookup
	// ***********************************************************
	logic [XLEN-1:0]     ea_sum;
	logic [XLEN-1:0]     ea_cut;
	logic [SEG_IDXW-1:0] seg_idx;
	logic [DESC_W-1:0]   desc_rd;
	logic                bridge_on;

	always_comb
	begin
		ea_sum    = EA_BASE + EA_DISP;
		// Upper half is dropped rather than sign-extended
		ea_cut    = narrow ? {ZERO_HI, ea_sum[HLEN-1:0]} : ea_sum;
		seg_idx   = ea_sum[HLEN-1:SEG_OFSW];
		bridge_on = BRIDGE_EN & narrow & ~SUBSET_32;
	end

	awmc_lookaside #(
		.ENTRIES (SEG_NUM),
		.IDX_W   (SEG_IDXW)
	) u_lookaside (
		.clock     (CLOCK),
		.rst       (RST),
		.ce        (CE),
		.wr_en     (LKA_WR & BRIDGE_EN),
		.wr_idx    (LKA_WR_IDX),
		.wr_data   (LKA_WR_DATA),
		.inval_all (LKA_INVAL_ALL & BRIDGE_EN),
		.rd_idx    (seg_idx),
		.rd_data   (desc_rd)
	);

	logic            ea_vld_ff;
	logic [XLEN-1:0] ea_ff;
	logic [VA_W-1:0] va_ff;
	logic            va_vld_ff;
	logic            fault_ff;
	logic            noexec_ff;
	logic            nxt_ea_vld;
	logic [XLEN-1:0] nxt_ea;
	logic [VA_W-1:0] nxt_va;
	logic            nxt_va_vld;
	logic            nxt_fault;
	logic            nxt_noexec;

	always_comb
	begin
		nxt_ea_vld = EA_VALID;
		nxt_ea     = ea_ff;
		nxt_va     = va_ff;
		nxt_va_vld = 1'b0;
		nxt_fault  = 1'b0;
		nxt_noexec = noexec_ff;
		if (EA_VALID)
		begin
			nxt_ea = ea_cut;
			if (bridge_on)
			begin
				if (desc_rd[DESC_VALID])
				begin
					// Offset within the 256-Mbyte segment passes unchanged
					nxt_va = {desc_rd[DESC_VSID_HI:DESC_VSID_LO],
						ea_sum[SEG_OFSW-1:0]};
					nxt_va_vld = 1'b1;
					nxt_noexec = desc_rd[DESC_NOEXEC];
				end
				else
				begin
					// Missing descriptor is left to the fault handler
					nxt_fault  = 1'b1;
					nxt_noexec = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			ea_vld_ff <= 1'b0;
			ea_ff     <= RST_WORD;
			va_ff     <= {VA_W{1'b0}};
			va_vld_ff <= 1'b0;
			fault_ff  <= 1'b0;
			noexec_ff <= 1'b0;
		end
		else if (CE)
		begin
			ea_vld_ff <= nxt_ea_vld;
			ea_ff     <= nxt_ea;
			va_ff     <= nxt_va;
			va_vld_ff <= nxt_va_vld;
			fault_ff  <= nxt_fault;
			noexec_ff <= nxt_noexec;
		end
	end

	assign EA_RSP_VALID = ea_vld_ff;
	assign EA_OUT       = ea_ff;
	assign VA_OUT       = va_ff;
	assign VA_VALID     = va_vld_ff;
	assign SEG_FAULT    = fault_ff;
	assign SEG_NOEXEC   = noexec_ff;

	// ***********************************************************
	// Loop count register
	// ***********************************************************
	logic [XLEN-1:0] loop_ff;
	logic            loop_zero_ff;
	logic [XLEN-1:0] nxt_loop;
	logic            nxt_loop_zero;

	always_comb
	begin
		nxt_loop = loop_ff;
		// Load has priority over a decrement in the same cycle
		if (LOOP_LOAD)
			nxt_loop = LOOP_LOAD_VAL;
		else if (LOOP_DECR)
			nxt_loop = loop_ff - {{(XLEN-1){1'b0}}, 1'b1};
		if (SUBSET_32)
			nxt_loop = {ZERO_HI, nxt_loop[HLEN-1:0]};
		// Full register keeps counting except on a 32-bit-only build, where the upper half is cleared; otherwise only the test narrows
		nxt_loop_zero = narrow ? (nxt_loop[HLEN-1:0] == ZERO_HI)
			: (nxt_loop == RST_WORD);
	end

	always_ff @(posedge CLOCK)
	begin
		if (RST)
		begin
			loop_ff      <= RST_WORD;
			loop_zero_ff <= 1'b1;
		end
		else if (CE)
		begin
			loop_ff      <= nxt_loop;
			loop_zero_ff <= nxt_loop_zero;
		end
	end

	assign LOOP_VALUE = loop_ff;
	assign LOOP_ZERO  = loop_zero_ff;

endmodule

// >>> verif/awmc_assertions.sv
`timescale 1ns/100ps

module awmc_assertions
	import awmc_pkg::*;
#(
	parameter bit SUBSET_32 = 1'b0,
	parameter bit BRIDGE_EN = 1'b1
)
(
	// Clock and mode
	input wire logic            CLOCK,
	input wire logic            RST,
	input wire logic            CE,
	input wire logic            ADDR_WIDTH_SELECT,
	input wire logic            MODE_64,
	// Arithmetic
	input wire logic            REQ_VALID,
	input wire logic [OP_W-1:0] OP_SEL,
	input wire logic [XLEN-1:0] OP_A,
	input wire logic [XLEN-1:0] OP_B,
	input wire logic            CARRY_IN,
	input wire logic            RSP_VALID,
	input wire logic            CARRY_OUT,
	// Address
	input wire logic            EA_VALID,
	input wire logic            EA_RSP_VALID,
	input wire logic [XLEN-1:0] EA_OUT,
	input wire logic [VA_W-1:0] VA_OUT,
	input wire logic            VA_VALID,
	input wire logic            SEG_FAULT,
	// Loop count
	input wire logic            LOOP_LOAD,
	input wire logic            LOOP_DECR,
	input wire logic [XLEN-1:0] LOOP_VALUE,
	input wire logic            LOOP_ZERO
);
	// ********
	// Reference narrow carry
	// ********
	logic [32:0] nxt_sum33;
	logic        c32_ff;

	always_comb
	begin
		nxt_sum33 = {1'b0, OP_A[31:0]} + {1'b0, OP_B[31:0]}
			+ {32'h0000_0000, CARRY_IN};
	end

	always_ff @(posedge CLOCK)
	begin
		c32_ff <= nxt_sum33[32];
	end

	// ********
	// Properties
	// ********
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	sequence narrow_ea_s;
		CE && EA_VALID && !MODE_64;
	endsequence

	mode_select_a: assert property (
		MODE_64 == (ADDR_WIDTH_SELECT && !SUBSET_32))
		else $error("mode output does not follow width select");
	rsp_pulse_a: assert property (
		CE |=> RSP_VALID == $past(REQ_VALID))
		else $error("answer pulse not one cycle after request");
	ea_narrow_a: assert property (
		narrow_ea_s |=> EA_RSP_VALID && EA_OUT[63:32] == 32'h0000_0000)
		else $error("narrow address not cut to 32 bits");
	carry_narrow_a: assert property (
		CE && REQ_VALID && !MODE_64 && OP_SEL == AWMC_OP_ADD
		|=> CARRY_OUT == c32_ff)
		else $error("narrow carry not from bit 31");
	ctr_narrow_a: assert property (
		CE && (LOOP_LOAD || LOOP_DECR) && !MODE_64
		|=> LOOP_ZERO == (LOOP_VALUE[31:0] == 32'h0000_0000))
		else $error("narrow count zero test wrong");
	seg_answer_a: assert property (
		narrow_ea_s ##0 (BRIDGE_EN && !SUBSET_32) |=> VA_VALID != SEG_FAULT)
		else $error("bridge lookup gave no single answer");
	va_offset_a: assert property (
		VA_VALID |-> EA_RSP_VALID && VA_OUT[27:0] == EA_OUT[27:0])
		else $error("segment offset not carried to translation");
	wide_nobridge_a: assert property (
		CE && EA_VALID && MODE_64 |=> !VA_VALID && !SEG_FAULT)
		else $error("bridge active in wide mode");
endmodule

bind awmc_top awmc_assertions #(.SUBSET_32(SUBSET_32),
	.BRIDGE_EN(BRIDGE_EN)) u_chk (.*);

// >>> verif/awmc_top_test.sv
`timescale 1ns/100ps

module awmc_top_test;
	import awmc_pkg::*;

	logic                CLOCK, RST, CE, ADDR_WIDTH_SELECT, MODE_64;
	logic                REQ_VALID, OP_DOUBLE, CARRY_IN, RSP_VALID;
	logic                CARRY_OUT, OVERFLOW, CMP_LT, CMP_GT, CMP_EQ;
	logic                EMUL_TRAP, EA_VALID, EA_RSP_VALID, VA_VALID;
	logic                SEG_FAULT, SEG_NOEXEC, LOOP_LOAD, LOOP_DECR;
	logic                LOOP_ZERO, LKA_WR, LKA_INVAL_ALL;
	logic [OP_W-1:0]     OP_SEL;
	logic [XLEN-1:0]     OP_A, OP_B, RESULT, EA_BASE, EA_DISP, EA_OUT;
	logic [XLEN-1:0]     LOOP_LOAD_VAL, LOOP_VALUE, LKA_WR_DATA;
	logic [VA_W-1:0]     VA_OUT;
	logic [SEG_IDXW-1:0] LKA_WR_IDX;
	int                  failures;
	int                  checks;

	awmc_top uut (.*);

	initial
	begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	// ********
	// Shared tasks
	// ********
	task automatic chk(input logic [VA_W-1:0] g, input logic [VA_W-1:0] e);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic stop_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Flags packed as carry, overflow, less; logic ops check less only, carry and overflow are masked
	task automatic arith(input logic w, input awmc_op_t op,
		input logic [XLEN-1:0] a, input logic [XLEN-1:0] b,
		input logic [XLEN-1:0] r, input logic [2:0] f);
		logic [2:0] m;
		logic       z;
		m = (op inside {AWMC_OP_AND, AWMC_OP_OR, AWMC_OP_XOR}) ? 3'b001 : 3'b111;
		z = w ? (r == 64'h0000_0000_0000_0000) : (r[31:0] == 32'h0000_0000);
		@(negedge CLOCK);
		ADDR_WIDTH_SELECT = w;
		REQ_VALID = 1'b1;
		OP_SEL = op;
		OP_A = a;
		OP_B = b;
		@(negedge CLOCK);
		REQ_VALID = 1'b0;
		chk(RSP_VALID, 1'b1);
		chk(RESULT, r);
		chk({CARRY_OUT, OVERFLOW, CMP_LT} & m, f & m);
		chk({CMP_GT, CMP_EQ}, {~f[0] & ~z, z});
		chk(EMUL_TRAP, 1'b0);
	endtask

	task automatic ea(input logic w, input logic [XLEN-1:0] base,
		input logic [XLEN-1:0] e, input logic [1:0] vf);
		@(negedge CLOCK);
		ADDR_WIDTH_SELECT = w;
		EA_VALID = 1'b1;
		EA_BASE = base;
		EA_DISP = 64'h0000_0000_0000_0010;
		@(negedge CLOCK);
		EA_VALID = 1'b0;
		chk(EA_RSP_VALID, 1'b1);
		chk(EA_OUT, e);
		chk({VA_VALID, SEG_FAULT}, vf);
	endtask

	task automatic slb(input logic [3:0] idx, input logic [XLEN-1:0] d,
		input logic inv);
		@(negedge CLOCK);
		LKA_WR = !inv;
		LKA_WR_IDX = idx;
		LKA_WR_DATA = d;
		LKA_INVAL_ALL = inv;
		@(negedge CLOCK);
		LKA_WR = 1'b0;
		LKA_INVAL_ALL = 1'b0;
	endtask

	// ********
	// Scenarios
	// ********
	task automatic test_mode;
		@(negedge CLOCK);
		ADDR_WIDTH_SELECT = 1'b1;
		#1 chk(MODE_64, 1'b1);
		@(negedge CLOCK);
		ADDR_WIDTH_SELECT = 1'b0;
		#1 chk(MODE_64, 1'b0);
		$display("mode test done");
	endtask

	// No trap expected: this build has full doubleword hardware
	task automatic test_arith;
		OP_DOUBLE = 1'b1;
		arith(0, AWMC_OP_ADD, 64'h0000_0000_7fff_ffff, 64'h0000_0000_0000_0001,
			64'h0000_0000_8000_0000, 3'b011);
		arith(1, AWMC_OP_ADD, 64'h0000_0000_7fff_ffff, 64'h0000_0000_0000_0001,
			64'h0000_0000_8000_0000, 3'b000);
		arith(0, AWMC_OP_ADD, 64'h0000_0000_ffff_ffff, 64'h0000_0000_0000_0001,
			64'h0000_0001_0000_0000, 3'b100);
		arith(1, AWMC_OP_ADD, 64'h7fff_ffff_ffff_ffff, 64'h0000_0000_0000_0001,
			64'h8000_0000_0000_0000, 3'b011);
		arith(0, AWMC_OP_SUB, 64'h0000_0000_0000_0000, 64'h0000_0000_0000_0001,
			64'hffff_ffff_ffff_ffff, 3'b001);
		arith(0, AWMC_OP_CMP, 64'h0000_0000_8000_0000, 64'h0000_0000_0000_0001,
			64'h0000_0000_7fff_ffff, 3'b111);
		arith(1, AWMC_OP_CMP, 64'h0000_0000_8000_0000, 64'h0000_0000_0000_0001,
			64'h0000_0000_7fff_ffff, 3'b100);
		arith(0, AWMC_OP_AND, 64'h0000_0000_ffff_0000, 64'h0000_0000_f0f0_f0f0,
			64'h0000_0000_f0f0_0000, 3'b001);
		arith(0, AWMC_OP_OR, 64'h0000_0000_0000_0000, 64'h0000_0001_0000_0000,
			64'h0000_0001_0000_0000, 3'b000);
		arith(1, AWMC_OP_XOR, 64'hffff_ffff_ffff_ffff, 64'h7fff_ffff_ffff_ffff,
			64'h8000_0000_0000_0000, 3'b001);
		$display("arith test done");
	endtask

	// A request while the enable is low must leave the answer not valid and the result frozen
	task automatic test_hold;
		@(negedge CLOCK);
		CE = 1'b0;
		REQ_VALID = 1'b1;
		OP_SEL = AWMC_OP_ADD;
		@(negedge CLOCK);
		chk(RSP_VALID, 1'b0);
		chk(RESULT, 64'h8000_0000_0000_0000);
		REQ_VALID = 1'b0;
		CE = 1'b1;
		$display("hold test done");
	endtask

	task automatic test_ea;
		ea(0, 64'h1234_5678_9abc_def0, 64'h0000_0000_9abc_df00, 2'b01);
		slb(4'h9, 64'h0000_0000_0abc_d0c0, 1'b0);
		ea(0, 64'h1234_5678_9abc_def0, 64'h0000_0000_9abc_df00, 2'b10);
		chk(VA_OUT, 80'h0000_0000_0abc_dabc_df00);
		chk(SEG_NOEXEC, 1'b1);
		ea(0, 64'h0000_0000_8fff_ffe0, 64'h0000_0000_8fff_fff0, 2'b01);
		ea(1, 64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_df00, 2'b00);
		slb(4'h0, 64'h0000_0000_0000_0000, 1'b1);
		ea(0, 64'h1234_5678_9abc_def0, 64'h0000_0000_9abc_df00, 2'b01);
		$display("address test done");
	endtask

	// Load then decrement; only the low word may decide zero when narrow
	task automatic test_ctr;
		for (int w = 0; w < 2; w++)
		begin
			@(negedge CLOCK);
			ADDR_WIDTH_SELECT = w[0];
			LOOP_LOAD = 1'b1;
			LOOP_LOAD_VAL = 64'h0000_0001_0000_0001;
			@(negedge CLOCK);
			LOOP_LOAD = 1'b0;
			LOOP_DECR = 1'b1;
			@(negedge CLOCK);
			LOOP_DECR = 1'b0;
			chk(LOOP_VALUE, 64'h0000_0001_0000_0000);
			chk(LOOP_ZERO, !w[0]);
		end
		$display("count test done");
	endtask

	initial
	begin
		failures = 0;
		checks = 0;
		RST = 1'b1;
		CE = 1'b1;
		{ADDR_WIDTH_SELECT, REQ_VALID, OP_DOUBLE, CARRY_IN, EA_VALID} = '0;
		{LOOP_LOAD, LOOP_DECR, LKA_WR, LKA_INVAL_ALL, LKA_WR_IDX} = '0;
		{OP_SEL, OP_A, OP_B, EA_BASE, EA_DISP} = '0;
		{LOOP_LOAD_VAL, LKA_WR_DATA} = '0;
		repeat (4) @(negedge CLOCK);
		RST = 1'b0;
		test_mode;
		test_arith;
		test_hold;
		test_ea;
		test_ctr;
		stop_test;
	end

	// Hang guard
	initial
	begin
		#100000;
		failures++;
		stop_test;
	end
endmodule
